/* File: data_memory_sfr_map_test.sv */
// testbench for the data memory decoder and register file
// assumes the core model drives all requests at the falling edge
`timescale 1ns/100ps
module data_memory_sfr_map_test;
  import dmsfr_pkg::*;
  logic              clk, nrst, fast_sel, rd, wr, flags_we, rvalid;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, flags_in, rdata;
  logic [3:0]        bank_sel;
  int                num_errors = 0;
  int                checked = 0;

  dmsfr_map dut (.clk(clk), .nrst(nrst), .addr(addr), .fast_sel(fast_sel),
    .rd(rd), .wr(wr), .wdata(wdata), .flags_we(flags_we),
    .flags_in(flags_in), .rdata(rdata), .rvalid(rvalid), .bank_sel(bank_sel));
  dmsfr_core core (.clk(clk), .rdata(rdata), .rvalid(rvalid), .addr(addr),
    .fast_sel(fast_sel), .rd(rd), .wr(wr), .wdata(wdata),
    .flags_we(flags_we), .flags_in(flags_in));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_b(input logic [11:0] a, input logic [7:0] d,
                      input logic fw = 1'b0);
    logic [7:0] q;
    logic       v;
    core.access(1'b1, 1'b0, a, d, fw, q, v);
    chk({7'h00, v}, 8'h00);
  endtask : wr_b

  task automatic rd_b(input logic f, input logic [11:0] a,
                      input logic [7:0] exp);
    logic [7:0] q;
    logic       v;
    core.access(1'b0, f, a, 8'h00, 1'b0, q, v);
    chk({7'h00, v}, 8'h01);
    chk(q, exp);
  endtask : rd_b

  task automatic wrap_up;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    nrst = 1'b0;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd_b(1'b0, 12'(A_PC_LOW + i), 8'h00);
    end
    wr_b(A_WACC, 8'h5A);
    rd_b(1'b0, A_WACC, 8'h5A);
    wr_b(12'h000, 8'hA1);
    wr_b(12'h0FF, 8'hB2);
    rd_b(1'b0, 12'h000, 8'hA1);
    rd_b(1'b0, 12'h0FF, 8'hB2);
    wr_b(12'h010, 8'hC3);
    rd_b(1'b1, 12'h010, 8'hC3);
    rd_b(1'b1, 12'h0E8, 8'h5A);
    wr_b(A_BANK_PTR, 8'hFF);
    rd_b(1'b0, A_BANK_PTR, 8'h0F);
    chk({4'h0, bank_sel}, 8'h0F);
    wr_b(12'hFC8, 8'h77);
    rd_b(1'b0, 12'hFC8, 8'h00);
    wr_b(12'hFD4, 8'h66);
    rd_b(1'b0, 12'hFD4, 8'h00);
    rd_b(1'b0, 12'hF80, 8'h00);
    wr_b(12'h100, 8'h15, 1'b1);
    rd_b(1'b0, 12'h100, 8'h00);
    rd_b(1'b0, A_ALU_FLAGS, 8'h15);
    rd_b(1'b0, 12'h000, 8'hA1);
    wr_b(A_IPTR0_LO, 8'h20);
    wr_b(A_IPTR0_HI, 8'hF0);
    rd_b(1'b0, A_IPTR0_HI, 8'h00);
    wr_b(A_IPORT0, 8'h3C);
    rd_b(1'b0, 12'h020, 8'h3C);
    rd_b(1'b0, A_IPORT0, 8'h3C);
    // a warm reset must clear core registers but leave ram alone
    wr_b(12'h030, 8'h4B);
    @(negedge clk);
    nrst = 1'b0;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    rd_b(1'b0, 12'h030, 8'h4B);
    rd_b(1'b0, A_WACC, 8'h00);
    wrap_up();
  end
endmodule : data_memory_sfr_map_test

/* File: dmsfr_core.sv */
// core-side model: issues one byte access per call, one idle cycle between
// assumes the decoder takes requests on rising clk and answers a cycle later
`timescale 1ns/100ps
module dmsfr_core
  import dmsfr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [DATA_W-1:0] rdata,
  input  wire logic              rvalid,
  output logic      [ADDR_W-1:0] addr,
  output logic                   fast_sel,
  output logic                   rd,
  output logic                   wr,
  output logic      [DATA_W-1:0] wdata,
  output logic                   flags_we,
  output logic      [DATA_W-1:0] flags_in
);
  initial begin
    {addr, fast_sel, rd, wr, wdata, flags_we, flags_in} = '0;
  end
  // released data lines flip so a stale value never passes for a good one
  task automatic access(input  logic              w,
                        input  logic              f,
                        input  logic [ADDR_W-1:0] a,
                        input  logic [DATA_W-1:0] d,
                        input  logic              fw,
                        output logic [DATA_W-1:0] q,
                        output logic              v);
    @(negedge clk);
    {addr, fast_sel, rd, wr, wdata} = {a, f, !w, w, d};
    {flags_we, flags_in} = {fw, d};
    @(negedge clk);
    q = rdata;
    v = rvalid;
    {rd, wr, flags_we} = 3'h0;
    wdata = ~d;
    flags_in = ~d;
  endtask : access
endmodule : dmsfr_core

/* File: dmsfr_map.sv */
// data memory decoder and core register file
// assumes the core holds addr/strobes stable for one clock per access
`timescale 1ns/100ps
// Functional notes
// R1: general ram starts at address zero and ends at 0FFh, the top of bank 0.
// R2: ram is unreset, so power-up leaves it unknown and other resets keep it.
// R3: the special area is the upper half of bank 15, F80h to FFFh.
// R4: unassigned special addresses read zero and store nothing.
// R5: the indirect port stores nothing and redirects through pointer 0.
// R6: addresses are 12 bits in sixteen 256-byte banks, only bank 0 built.
// R7: unbuilt banks drop writes and read zero; flag updates still go through.
// R8: fast window offsets below 80h hit bank 0, the rest hit the special area.
// R9: upper four bank pointer bits read zero and ignore writes.
// R10: each access takes one cycle; writes land on the closing clock edge.
module dmsfr_map
  import dmsfr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              fast_sel,
  input  wire logic              rd,
  input  wire logic              wr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              flags_we,
  input  wire logic [DATA_W-1:0] flags_in,
  output logic      [DATA_W-1:0] rdata,
  output logic                   rvalid,
  output logic      [3:0]        bank_sel
);
  logic [DATA_W-1:0] alu_flags, bank_pointer, working_accumulator;
  logic [DATA_W-1:0] iptr0_lo, iptr0_hi, pc_low, pc_hold_h, pc_hold_u;
  logic [DATA_W-1:0] stk_ptr, tos_low, tos_high, tos_upper;
  logic [DATA_W-1:0] ram_rdata;
  logic              ram_rd_q;

  // fast window and banked addresses resolve to one 12-bit address
  wire [ADDR_W-1:0] fast_addr = (addr[7:0] < ACC_HALF) ?
                       {BANK_FIRST, addr[7:0]} :
                       {BANK_LAST, addr[7:0]};                   // see R8
  wire [ADDR_W-1:0] eff0 = fast_sel ? fast_addr : addr;
  wire is_iport = (eff0 == A_IPORT0);
  // indirect port redirects; a pointer aimed at itself reads zero
  wire [ADDR_W-1:0] ind_addr = {iptr0_hi[3:0], iptr0_lo};
  wire [ADDR_W-1:0] eff = is_iport ? ind_addr : eff0;            // see R5
  wire ind_loop = is_iport && (ind_addr == A_IPORT0);
  wire in_sfr   = (eff[11:8] == BANK_LAST) && (eff[7:0] >= SFR_LOW); // see R3
  wire in_ram   = (eff[11:8] == BANK_FIRST);                     // see R1 R6
  wire wr_ok    = wr && !ind_loop;
  wire ram_we   = wr_ok && in_ram;                               // see R7
  wire sfr_we   = wr_ok && in_sfr;

  function automatic logic hit(input logic [ADDR_W-1:0] a);
    hit = sfr_we && (eff == a);
  endfunction

  wire [DATA_W-1:0] next_flags = hit(A_ALU_FLAGS) ? wdata :
                                 (flags_we ? flags_in : alu_flags);

  dmsfr_ram u_ram (
    .clk   (clk),
    .we    (ram_we),                                             // see R10
    .addr  (eff[RAM_W-1:0]),
    .wdata (wdata),
    .rdata (ram_rdata)
  );

  logic [DATA_W-1:0] sfr_rd;
  always_comb begin
    sfr_rd = RST_ZERO;                                           // see R4
    unique case (eff)
      A_ALU_FLAGS: sfr_rd = alu_flags;
      A_BANK_PTR:  sfr_rd = bank_pointer & BANK_PTR_MASK;        // see R9
      A_WACC:      sfr_rd = working_accumulator;
      A_IPTR0_LO:  sfr_rd = iptr0_lo;
      A_IPTR0_HI:  sfr_rd = iptr0_hi & IPTR_HI_MASK;
      A_PC_LOW:    sfr_rd = pc_low;
      A_PC_HOLD_H: sfr_rd = pc_hold_h;
      A_PC_HOLD_U: sfr_rd = pc_hold_u & PC_U_MASK;
      A_STK_PTR:   sfr_rd = stk_ptr & STK_MASK;
      A_TOS_LOW:   sfr_rd = tos_low;
      A_TOS_HIGH:  sfr_rd = tos_high;
      A_TOS_UPPER: sfr_rd = tos_upper & PC_U_MASK;
      default:     sfr_rd = RST_ZERO;
    endcase
  end
  wire [DATA_W-1:0] next_rdata = (in_sfr && !ind_loop) ? sfr_rd : RST_ZERO;

  // core registers: the ones without a documented reset also clear, harmless
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alu_flags           <= RST_ZERO;
      bank_pointer        <= RST_ZERO;
      working_accumulator <= RST_ZERO;
      iptr0_lo            <= RST_ZERO;
      iptr0_hi            <= RST_ZERO;
      pc_low              <= RST_ZERO;
      pc_hold_h           <= RST_ZERO;
      pc_hold_u           <= RST_ZERO;
      stk_ptr             <= RST_ZERO;
      tos_low             <= RST_ZERO;
      tos_high            <= RST_ZERO;
      tos_upper           <= RST_ZERO;
    end else begin
      alu_flags <= next_flags;                                   // see R7
      if (hit(A_BANK_PTR))  bank_pointer <= wdata & BANK_PTR_MASK; // see R9
      if (hit(A_WACC))      working_accumulator <= wdata;
      if (hit(A_IPTR0_LO))  iptr0_lo  <= wdata;
      if (hit(A_IPTR0_HI))  iptr0_hi  <= wdata & IPTR_HI_MASK;
      if (hit(A_PC_LOW))    pc_low    <= wdata;
      if (hit(A_PC_HOLD_H)) pc_hold_h <= wdata;
      if (hit(A_PC_HOLD_U)) pc_hold_u <= wdata & PC_U_MASK;
      if (hit(A_STK_PTR))   stk_ptr   <= wdata & STK_MASK;
      if (hit(A_TOS_LOW))   tos_low   <= wdata;
      if (hit(A_TOS_HIGH))  tos_high  <= wdata;
      if (hit(A_TOS_UPPER)) tos_upper <= wdata & PC_U_MASK;
    end
  end

  logic [DATA_W-1:0] sfr_rdata_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sfr_rdata_q <= RST_ZERO;
      ram_rd_q    <= 1'b0;
      rvalid      <= 1'b0;
      bank_sel    <= 4'h0;
    end else begin
      sfr_rdata_q <= next_rdata;
      ram_rd_q    <= rd && in_ram && !ind_loop;
      rvalid      <= rd;                                         // see R10
      bank_sel    <= bank_pointer[3:0];
    end
  end

  // read data muxed from two flops; the mux drives the output port directly, with no register after it
  always_comb begin
    rdata = ram_rd_q ? ram_rdata : sfr_rdata_q;
  end

  // a write with the high nibble set is the easy way to break the mask
  property p_bank_hi_zero;
    @(posedge clk) disable iff (!nrst)
      (bank_pointer & ~BANK_PTR_MASK) == RST_ZERO;
  endproperty
  a_bank_hi_zero: assert property (p_bank_hi_zero) // see R9
    else $error("bank pointer upper bits set");
  property p_bank_sel_follow;
    @(posedge clk) disable iff (!nrst)
      1'b1 |=> bank_sel == $past(bank_pointer[3:0]);
  endproperty
  a_bank_sel_follow: assert property (p_bank_sel_follow) // see R6
    else $error("bank select output lags pointer");
  property p_iptr_hi_zero;
    @(posedge clk) disable iff (!nrst)
      (iptr0_hi & ~IPTR_HI_MASK) == RST_ZERO;
  endproperty
  a_iptr_hi_zero: assert property (p_iptr_hi_zero) // see R5
    else $error("pointer high bits beyond the address kept");
  property p_unbuilt_zero;
    @(posedge clk) disable iff (!nrst)
      (rd && !in_ram && !in_sfr) |=> (rdata == RST_ZERO && rvalid);
  endproperty
  a_unbuilt_zero: assert property (p_unbuilt_zero) // see R7
    else $error("unbuilt bank read not zero");
  property p_hole_zero;
    @(posedge clk) disable iff (!nrst)
      (rd && in_sfr && eff == 12'hFD4 && !ind_loop) |=> rdata == RST_ZERO;
  endproperty
  a_hole_zero: assert property (p_hole_zero) // see R4
    else $error("unassigned special read not zero");
  property p_wacc_write;
    @(posedge clk) disable iff (!nrst)
      (wr && eff == A_WACC && !is_iport) |=>
        working_accumulator == $past(wdata);
  endproperty
  a_wacc_write: assert property (p_wacc_write) // see R10
    else $error("accumulator write lost");
  property p_fast_low;
    @(posedge clk) disable iff (!nrst)
      (fast_sel && addr[7] == 1'b0 && !is_iport) |-> eff[11:8] == BANK_FIRST;
  endproperty
  a_fast_low: assert property (p_fast_low) // see R8
    else $error("fast window low half misrouted");
  property p_fast_high;
    @(posedge clk) disable iff (!nrst)
      (fast_sel && addr[7] && !is_iport) |-> in_sfr;
  endproperty
  a_fast_high: assert property (p_fast_high) // see R3
    else $error("fast window high half misrouted");
  property p_iport_redirect;
    @(posedge clk) disable iff (!nrst)
      (wr && is_iport && !ind_loop && iptr0_hi[3:0] == BANK_FIRST) |->
        (ram_we && eff[RAM_W-1:0] == iptr0_lo);
  endproperty
  a_iport_redirect: assert property (p_iport_redirect) // see R5
    else $error("indirect port not redirected");
  property p_flags_on_unbuilt;
    @(posedge clk) disable iff (!nrst)
      (flags_we && !hit(A_ALU_FLAGS)) |=> alu_flags == $past(flags_in);
  endproperty
  a_flags_on_unbuilt: assert property (p_flags_on_unbuilt) // see R7
    else $error("flag update lost");
  property p_ram_wr;
    @(posedge clk) disable iff (!nrst)
      (wr && eff[11:8] != BANK_FIRST) |-> !ram_we;
  endproperty
  a_ram_wr: assert property (p_ram_wr) // see R1
    else $error("ram written outside bank zero");
  c_ram_rd: cover property (@(posedge clk) disable iff (!nrst) rd && in_ram);
  c_ind_wr: cover property (@(posedge clk) disable iff (!nrst) wr && is_iport);
  c_fast_sfr: cover property (@(posedge clk) disable iff (!nrst)
    fast_sel && in_sfr && rd);
  c_unbuilt_flags: cover property (@(posedge clk) disable iff (!nrst)
    wr && flags_we && !in_ram && !in_sfr);
  // rvalid is the only timing promise the core sees, so pin it both ways
  property p_rvalid_pulse;
    @(posedge clk) disable iff (!nrst) rd |=> rvalid;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) // see R10
    else $error("read not answered next cycle");
  property p_rvalid_drop;
    @(posedge clk) disable iff (!nrst) !rd |=> !rvalid;
  endproperty
  a_rvalid_drop: assert property (p_rvalid_drop) // see R10
    else $error("answer without a read");
endmodule : dmsfr_map

/* File: dmsfr_pkg.sv */
// package for the data memory decoder and register file
// assumes a 12-bit byte address from the core and one core clock
package dmsfr_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int RAM_W  = 8;           // one implemented bank of 256 bytes
  localparam logic [3:0] BANK_FIRST = 4'h0;
  localparam logic [3:0] BANK_LAST  = 4'hF;
  localparam logic [7:0] SFR_LOW    = 8'h80;  // lower edge of special area
  localparam logic [7:0] ACC_HALF   = 8'h80;  // fast window split point
  localparam logic [11:0] A_ALU_FLAGS = 12'hFD8;
  localparam logic [11:0] A_BANK_PTR  = 12'hFE0;
  localparam logic [11:0] A_WACC      = 12'hFE8;
  localparam logic [11:0] A_IPTR0_LO  = 12'hFE9;
  localparam logic [11:0] A_IPTR0_HI  = 12'hFEA;
  localparam logic [11:0] A_IPORT0    = 12'hFEF;
  localparam logic [11:0] A_PC_LOW    = 12'hFF9;
  localparam logic [11:0] A_PC_HOLD_H = 12'hFFA;
  localparam logic [11:0] A_PC_HOLD_U = 12'hFFB;
  localparam logic [11:0] A_STK_PTR   = 12'hFFC;
  localparam logic [11:0] A_TOS_LOW   = 12'hFFD;
  localparam logic [11:0] A_TOS_HIGH  = 12'hFFE;
  localparam logic [11:0] A_TOS_UPPER = 12'hFFF;
  localparam logic [7:0] BANK_PTR_MASK = 8'h0F;
  localparam logic [7:0] IPTR_HI_MASK  = 8'h0F;
  localparam logic [7:0] PC_U_MASK     = 8'h1F;
  localparam logic [7:0] STK_MASK      = 8'hDF;
  localparam logic [7:0] RST_ZERO      = 8'h00;
endpackage : dmsfr_pkg

/* File: dmsfr_ram.sv */
// general ram array, one bank of byte storage
// assumes the decoder gives a write strobe only for implemented ram
`timescale 1ns/100ps
module dmsfr_ram
  import dmsfr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              we,
  input  wire logic [RAM_W-1:0]  addr,
  input  wire logic [DATA_W-1:0] wdata,
  output logic      [DATA_W-1:0] rdata
);
  logic [DATA_W-1:0] mem [2**RAM_W];

  // no reset: contents survive every reset and start unknown at power-up
  always_ff @(posedge clk) begin                    // see R2
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : dmsfr_ram
